// File: rtl/fst_regs.svh
// Purpose : register map, field positions, reset values and timing counts
// Assumes : 32-bit AHB-Lite register bus, 40 MHz clock
// Notes   : definitions only
`ifndef FST_REGS_SVH
`define FST_REGS_SVH

// byte offsets, one word each
`define CTRL_OFS       8'h00
`define CMD_OFS        8'h04
`define RATE_OFS       8'h08
`define EXP_ABS_OFS    8'h0c
`define EXP_TICKS_OFS  8'h10
`define BURST_OFS      8'h14
`define STATUS_OFS     8'h18
`define IGNORED_OFS    8'h1c

// control word fields
`define CTRL_MODE_BIT    0
`define CTRL_RUN_LO      1
`define CTRL_RUN_HI      2
`define CTRL_ORG_LO      3
`define CTRL_ORG_HI      4
`define CTRL_POL_BIT     5
`define CTRL_RATE_BIT    6
`define CTRL_ACQ_BIT     7
`define CTRL_WIDTH_BIT   8
`define CTRL_RAW_BIT     9
`define CTRL_KIND_BIT    10

// command word bits, write one to act
`define CMD_BEGIN_BIT  0
`define CMD_END_BIT    1
`define CMD_TRIG_BIT   2

// status word fields
`define STAT_STATE_HI  3
`define STAT_WAIT_BIT  4
`define STAT_FRM_LO    16

// reset values
`define RUN_MODE_RST   2'h1
`define ORIGIN_RST     2'h1
`define RATE_RST       32'h0000_0000
`define EXP_ABS_RST    20'h00bb8
`define EXP_TICKS_RST  32'h0000_0064
`define BURST_RST      16'h0001

// timing
`define CLK_PERIOD_NS  25
`define NS_PER_US      1000
`define CYC_PER_US     (`NS_PER_US / `CLK_PERIOD_NS)

`endif

// File: rtl/fst_pkg.sv
// Purpose : types shared by the frame start trigger design
// Assumes : nothing
// Notes   : state codes are one-hot
package fst_pkg;

  typedef enum logic [3:0] {
    S_IDLE       = 4'h1,
    S_WAIT_ACQ   = 4'h2,
    S_WAIT_FRAME = 4'h4,
    S_BUSY       = 4'h8
  } trig_state_type;

  typedef enum logic [1:0] {
    ORG_HOST  = 2'h0,
    ORG_PIN_A = 2'h1,
    ORG_PIN_B = 2'h2
  } origin_type;

  typedef enum logic [1:0] {
    RUN_ONE_SHOT   = 2'h0,
    RUN_CONTINUOUS = 2'h1
  } run_mode_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pulse;
  } edge_state_type;

  typedef struct packed {
    trig_state_type state;
    logic           mode_on;
    run_mode_type   run_mode;
    origin_type     origin;
    logic           polarity;
    logic           rate_on;
    logic           acq_en;
    logic           width_exp;
    logic           raw_sel;
    logic           kind_sel;
    logic [31:0]    rate_period;
    logic [19:0]    exp_abs;
    logic [31:0]    exp_ticks;
    logic [15:0]    burst;
    logic [15:0]    frames;
    logic           burst_done;
    logic [31:0]    gap;
    logic [15:0]    ignored;
    logic           dp_wr;
    logic [7:0]     dp_addr;
    logic [31:0]    hrdata;
    logic           hready;
    logic           fs;
    logic [31:0]    exp_out;
    logic           by_width;
    logic           waiting;
  } trig_regs_type;

endpackage : fst_pkg

// File: rtl/edge_pick.sv
// Purpose : line synchroniser and single-cycle edge pulse
// Assumes : line_i asynchronous to clk_i
// Notes   : pulse_o is one cycle per qualifying transition
module edge_pick (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic line_i,
  input  wire logic falling_i,
  output logic      pulse_o
);
  import fst_pkg::*;

  edge_state_type s_q;
  edge_state_type s_d;

  always_comb begin
    s_d       = s_q;
    s_d.sync1 = line_i;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    // only the second stage (sync2) and its delayed copy prev feed the edge compare
    s_d.pulse = falling_i ? (s_q.prev & ~s_q.sync2) : (~s_q.prev & s_q.sync2);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_o = s_q.pulse;
endmodule : edge_pick

// File: rtl/frame_start_trigger_ctrl.sv
// Purpose : frame start trigger controller with AHB-Lite registers
// Assumes : single clock, synchronous reset, word-only single transfers
// Notes   : trigger lines pass a two-stage synchroniser before use
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`include "fst_regs.svh"

module frame_start_trigger_ctrl #(
  parameter int unsigned RAW_TICK_CYCLES = 1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        input_pin_a_i,
  input  wire logic        gpio_pin_b_i,
  input  wire logic [31:0] min_period_i,
  input  wire logic        frame_busy_i,
  output logic             frame_start_o,
  output logic      [31:0] exposure_cycles_o,
  output logic             exposure_by_width_o,
  output logic             waiting_o
);
  import fst_pkg::*;

  trig_regs_type s_q;
  trig_regs_type s_d;

  logic [1:0]  line_pulse;
  logic [1:0]  line_in;
  logic        begin_cmd;
  logic        end_cmd;
  logic        host_cmd;
  logic        sel_trig;
  logic        int_tick;
  logic        accept;
  logic        acq_trig;
  logic [31:0] eff_period;
  logic [31:0] abs_cycles;
  logic [31:0] raw_cycles;
  logic [31:0] rdata;
  logic [15:0] frames_inc;

  assign line_in = {gpio_pin_b_i, input_pin_a_i};

  ////////////////////////////////////////////////////////////////////////////
  // line edge detection, one per trigger line
  for (genvar i = 0; i < 2; i++) begin : g_line
    edge_pick u_edge (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .line_i    (line_in[i]),
      .falling_i (s_q.polarity),
      .pulse_o   (line_pulse[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger selection and rate
  always_comb begin
    sel_trig = 1'b0;
    case (s_q.origin)
      ORG_HOST:  sel_trig = host_cmd & ~s_q.kind_sel;
      ORG_PIN_A: sel_trig = line_pulse[0];
      ORG_PIN_B: sel_trig = line_pulse[1];
      default:   sel_trig = 1'b0;
    endcase
  end

  // larger period means lower rate; never faster than the sensor allows
  assign eff_period = (s_q.rate_on && (s_q.rate_period > min_period_i)) ?
                      s_q.rate_period : min_period_i;
  assign int_tick   = ~s_q.mode_on & (s_q.gap >= eff_period);
  assign accept     = (s_q.state == S_WAIT_FRAME) &
                      (s_q.mode_on ? sel_trig : int_tick);
  assign acq_trig   = host_cmd & s_q.kind_sel;
  assign abs_cycles = 32'(s_q.exp_abs * `CYC_PER_US);
  assign raw_cycles = 32'(s_q.exp_ticks * RAW_TICK_CYCLES);
  assign frames_inc = s_q.frames + 16'h0001;

  // command pulses decoded apart, so the trigger path never runs through s_d
  always_comb begin
    begin_cmd = 1'b0;
    end_cmd   = 1'b0;
    host_cmd  = 1'b0;
    if (s_q.dp_wr && (s_q.dp_addr == `CMD_OFS)) begin
      begin_cmd = hwdata_i[`CMD_BEGIN_BIT];
      end_cmd   = hwdata_i[`CMD_END_BIT];
      host_cmd  = hwdata_i[`CMD_TRIG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (haddr_i[7:0] == `CTRL_OFS) begin
      rdata[`CTRL_MODE_BIT]             = s_q.mode_on;
      rdata[`CTRL_RUN_HI:`CTRL_RUN_LO]  = s_q.run_mode;
      rdata[`CTRL_ORG_HI:`CTRL_ORG_LO]  = s_q.origin;
      rdata[`CTRL_POL_BIT]              = s_q.polarity;
      rdata[`CTRL_RATE_BIT]             = s_q.rate_on;
      rdata[`CTRL_ACQ_BIT]              = s_q.acq_en;
      rdata[`CTRL_WIDTH_BIT]            = s_q.width_exp;
      rdata[`CTRL_RAW_BIT]              = s_q.raw_sel;
      rdata[`CTRL_KIND_BIT]             = s_q.kind_sel;
    end else if (haddr_i[7:0] == `RATE_OFS) begin
      rdata = s_q.rate_period;
    end else if (haddr_i[7:0] == `EXP_ABS_OFS) begin
      rdata[19:0] = s_q.exp_abs;
    end else if (haddr_i[7:0] == `EXP_TICKS_OFS) begin
      rdata = s_q.exp_ticks;
    end else if (haddr_i[7:0] == `BURST_OFS) begin
      rdata[15:0] = s_q.burst;
    end else if (haddr_i[7:0] == `STATUS_OFS) begin
      rdata[`STAT_STATE_HI:0]          = s_q.state;
      rdata[`STAT_WAIT_BIT]            = s_q.waiting;
      rdata[31:`STAT_FRM_LO]           = s_q.frames;
    end else if (haddr_i[7:0] == `IGNORED_OFS) begin
      rdata[15:0] = s_q.ignored;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d       = s_q;
    s_d.fs    = 1'b0;

    // bus: address phase, read data sampled at the address phase
    s_d.dp_wr  = 1'b0;
    s_d.hready = 1'b1;
    if (hsel_i && hready_i && htrans_i[1]) begin
      s_d.dp_wr   = hwrite_i;
      s_d.dp_addr = haddr_i[7:0];
      s_d.hrdata  = hwrite_i ? 32'h0000_0000 : rdata;
    end

    // bus: write data phase
    if (s_q.dp_wr) begin
      if (s_q.dp_addr == `CTRL_OFS) begin
        s_d.mode_on   = hwdata_i[`CTRL_MODE_BIT];
        s_d.run_mode  = run_mode_type'(hwdata_i[`CTRL_RUN_HI:`CTRL_RUN_LO]);
        s_d.origin    = origin_type'(hwdata_i[`CTRL_ORG_HI:`CTRL_ORG_LO]);
        s_d.polarity  = hwdata_i[`CTRL_POL_BIT];
        s_d.rate_on   = hwdata_i[`CTRL_RATE_BIT];
        s_d.acq_en    = hwdata_i[`CTRL_ACQ_BIT];
        s_d.width_exp = hwdata_i[`CTRL_WIDTH_BIT];
        s_d.raw_sel   = hwdata_i[`CTRL_RAW_BIT];
        s_d.kind_sel  = hwdata_i[`CTRL_KIND_BIT];
      end else if (s_q.dp_addr == `RATE_OFS) begin
        s_d.rate_period = hwdata_i;
      end else if (s_q.dp_addr == `EXP_ABS_OFS) begin
        s_d.exp_abs = hwdata_i[19:0];
      end else if (s_q.dp_addr == `EXP_TICKS_OFS) begin
        s_d.exp_ticks = hwdata_i;
      end else if (s_q.dp_addr == `BURST_OFS) begin
        s_d.burst = hwdata_i[15:0];
      end
    end

    // cycles since the last frame start, saturating
    if (accept) begin
      // the start cycle counts too, so the period equals eff_period exactly
      s_d.gap = 32'h0000_0001;
    end else if (s_q.gap != 32'hffff_ffff) begin
      s_d.gap = s_q.gap + 32'h0000_0001;
    end

    // over-triggering is only counted, never queued
    if (s_q.mode_on && sel_trig && !accept) begin
      s_d.ignored = s_q.ignored + 16'h0001;
    end

    case (s_q.state)
      S_IDLE: begin
        // invalid run modes never arm the controller
        if (begin_cmd && (s_q.run_mode == RUN_ONE_SHOT ||
                          s_q.run_mode == RUN_CONTINUOUS)) begin
          s_d.state      = s_q.acq_en ? S_WAIT_ACQ : S_WAIT_FRAME;
          s_d.frames     = 16'h0000;
          s_d.burst_done = 1'b0;
          s_d.gap        = 32'hffff_ffff;
        end
      end
      S_WAIT_ACQ: begin
        if (acq_trig) begin
          s_d.state      = S_WAIT_FRAME;
          s_d.frames     = 16'h0000;
          s_d.burst_done = 1'b0;
        end
      end
      S_WAIT_FRAME: begin
        if (accept) begin
          s_d.fs         = 1'b1;
          s_d.frames     = frames_inc;
          s_d.burst_done = s_q.acq_en && (frames_inc >= s_q.burst);
          s_d.by_width   = 1'b0;
          if (!s_q.mode_on) begin
            s_d.exp_out = s_q.raw_sel ? raw_cycles : abs_cycles;
          end else if (s_q.origin == ORG_HOST) begin
            s_d.exp_out = abs_cycles;
          end else begin
            // value stays loaded as a fallback when width mode is used
            s_d.exp_out  = abs_cycles;
            s_d.by_width = s_q.width_exp;
          end
          s_d.state = (s_q.run_mode == RUN_ONE_SHOT) ? S_IDLE : S_BUSY;
        end
      end
      S_BUSY: begin
        if (!frame_busy_i) begin
          s_d.state = s_q.burst_done ? S_WAIT_ACQ : S_WAIT_FRAME;
        end
      end
      default: begin
        s_d.state = S_IDLE;
      end
    endcase

    if (end_cmd) begin
      s_d.state = S_IDLE;
    end
    s_d.waiting = (s_d.state == S_WAIT_FRAME);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q             <= '0;
      s_q.state       <= S_IDLE;
      s_q.run_mode    <= run_mode_type'(`RUN_MODE_RST);
      s_q.origin      <= origin_type'(`ORIGIN_RST);
      s_q.rate_period <= `RATE_RST;
      s_q.exp_abs     <= `EXP_ABS_RST;
      s_q.exp_ticks   <= `EXP_TICKS_RST;
      s_q.burst       <= `BURST_RST;
      s_q.hready      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata_o            = s_q.hrdata;
  assign hreadyout_o         = s_q.hready;
  assign hresp_o             = 1'b0;
  assign frame_start_o       = s_q.fs;
  assign exposure_cycles_o   = s_q.exp_out;
  assign exposure_by_width_o = s_q.by_width;
  assign waiting_o           = s_q.waiting;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_idle_to_wait;
    (s_q.state == S_IDLE) ##1 (s_q.state == S_WAIT_FRAME);
  endsequence

  sequence s_busy_release;
    (s_q.state == S_BUSY) && s_q.burst_done && !frame_busy_i && !end_cmd;
  endsequence

  AST_FS_FROM_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.fs |-> ($past(s_q.state) == S_WAIT_FRAME))
    else $error("frame start outside waiting status");

  AST_LEAVE_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.fs |-> (s_q.state != S_WAIT_FRAME) && !s_q.waiting)
    else $error("still waiting after accepted trigger");

  AST_ENTER_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_idle_to_wait |-> $past(begin_cmd) && !$past(s_q.acq_en))
    else $error("waiting entered without begin command");

  AST_HOST_TRIG: assert property (@(posedge clk_i) disable iff (rst_i)
    ((s_q.state == S_WAIT_FRAME) && s_q.mode_on && (s_q.origin == ORG_HOST) &&
     host_cmd && !s_q.kind_sel && !end_cmd) |=> s_q.fs)
    else $error("host trigger not accepted");

  AST_PIN_A_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    ((s_q.state == S_WAIT_FRAME) && s_q.mode_on && (s_q.origin == ORG_PIN_A) &&
     line_pulse[0] && !end_cmd) |=> s_q.fs)
    else $error("line edge not accepted");

  AST_ONLY_SELECTED: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.mode_on && (s_q.origin == ORG_HOST) && !host_cmd) |=> !s_q.fs)
    else $error("trigger from unselected origin");

  AST_ONE_SHOT: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.fs && (s_q.run_mode == RUN_ONE_SHOT)) |-> (s_q.state == S_IDLE) ##1 !s_q.fs)
    else $error("one-shot produced more than one trigger");

  AST_RATE_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.fs && !$past(s_q.mode_on) && ($past(s_q.gap) != 32'hffff_ffff)) |->
      ($past(s_q.gap) >= $past(min_period_i)) &&
      (!$past(s_q.rate_on) || ($past(s_q.gap) >= $past(s_q.rate_period))))
    else $error("internal trigger faster than allowed");

  AST_END_STOPS: assert property (@(posedge clk_i) disable iff (rst_i)
    end_cmd |=> (s_q.state == S_IDLE) ##1 !s_q.fs)
    else $error("end command did not stop triggers");

  AST_BURST_END: assert property (@(posedge clk_i) disable iff (rst_i)
    s_busy_release |=> (s_q.state == S_WAIT_ACQ))
    else $error("burst complete but still waiting for frames");

  AST_FREE_EXPOSURE: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.fs && !$past(s_q.mode_on) && !$past(s_q.raw_sel)) |->
      (s_q.exp_out == $past(abs_cycles)))
    else $error("free run exposure not from absolute value");

  AST_ORIGIN_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (s_q.origin == ORG_PIN_A))
    else $error("origin not pin a after reset");

endmodule : frame_start_trigger_ctrl

// File: sim/trig_source_model.sv
// Purpose : far side model: trigger lines and sensor busy
// Assumes : bench calls lines() right after a rising edge
// Notes   : lines idle low; pin b is only ever an input of the block
module trig_source_model (
  input  wire logic       clk_i,
  input  wire logic       frame_start_i,
  input  wire logic [7:0] busy_len_i,
  output logic            pin_a_o,
  output logic            pin_b_o,
  output logic            frame_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] left_q;

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pin_a_o      = 1'b0;
    pin_b_o      = 1'b0;
    left_q       = 8'h00;
  end

  // busy from the frame start cycle on: the block checks busy in that same cycle
  assign frame_busy_o = (frame_start_i === 1'b1) || (left_q != 8'h00);

  // sensor stays busy for busy_len cycles after each frame start
  always @(posedge clk_i) begin
    if (frame_start_i === 1'b1) begin
      left_q <= busy_len_i;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // levels only; at most one edge per line per call, pin b never driven by the block
  task automatic lines(input logic [1:0] m);
    pin_a_o <= m[0];
    pin_b_o <= m[1];
  endtask : lines
endmodule : trig_source_model

// File: sim/frame_start_trigger_ctrl_tb.sv
// Purpose : self-checking bench for the frame start trigger controller
// Assumes : one slave, hready tied to hreadyout, zero wait states
// Notes   : frame starts counted on the falling edge to avoid races
`include "fst_regs.svh"

module frame_start_trigger_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] MINP = 32'd20;
  localparam logic [31:0] LINE_CTL [4] = '{32'h10b, 32'h12b, 32'h113, 32'h133};

  logic        clk_i, rst_i, hsel_i, hwrite_i, hready_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, min_period_i, exposure_cycles_o;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  logic        hreadyout_o, hresp_o, pin_a, pin_b, frame_busy;
  logic        frame_start_o, exposure_by_width_o, waiting_o;
  logic [7:0]  busy_len;
  logic [31:0] rd;
  int          bad_count, cmp_count, fs_count, fs_gap, fs_last, cyc, n;

  assign hready_i = hreadyout_o;

  frame_start_trigger_ctrl #(.RAW_TICK_CYCLES(1)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .input_pin_a_i(pin_a),
    .gpio_pin_b_i(pin_b), .min_period_i(min_period_i),
    .frame_busy_i(frame_busy), .frame_start_o(frame_start_o),
    .exposure_cycles_o(exposure_cycles_o),
    .exposure_by_width_o(exposure_by_width_o), .waiting_o(waiting_o));

  trig_source_model i_model (
    .clk_i(clk_i), .frame_start_i(frame_start_o), .busy_len_i(busy_len),
    .pin_a_o(pin_a), .pin_b_o(pin_b), .frame_busy_o(frame_busy));

  always #12.5 clk_i = ~clk_i;

  // interval between frame starts in whole cycles
  always @(negedge clk_i) begin
    cyc++;
    if (frame_start_o === 1'b1) begin
      fs_count++;
      fs_gap  = cyc - fs_last;
      fs_last = cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one single transfer; address held until hready, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask : rdc

  task automatic idle(input int k);
    repeat (k) @(posedge clk_i);
  endtask : idle

  // bounded only by the watchdog
  task automatic wait_fs(input int k);
    int t;
    t = fs_count + k;
    wait (fs_count >= t);
    @(posedge clk_i);
  endtask : wait_fs

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    close_out();
  end

  initial begin
    clk_i = 1'b0; rst_i = 1'b1; hsel_i = 1'b0; haddr_i = 32'h0; htrans_i = 2'h0;
    hwrite_i = 1'b0; hsize_i = 3'h2; hwdata_i = 32'h0; min_period_i = MINP;
    busy_len = 8'h03;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("waiting", 32'h0, {31'h0, waiting_o});
    chk("hresp", 32'h0, {31'h0, hresp_o});
    rdc("ctrl", `CTRL_OFS, 32'h0000000a, 32'hffffffff);
    rdc("exp_abs", `EXP_ABS_OFS, 32'h00000bb8, 32'hffffffff);
    rdc("exp_ticks", `EXP_TICKS_OFS, 32'h00000064, 32'hffffffff);
    rdc("burst", `BURST_OFS, 32'h00000001, 32'hffffffff);
    rdc("status", `STATUS_OFS, 32'h00000001, 32'h0000001f);
    rdc("unmapped", 8'h20, 32'h0, 32'hffffffff);
    // free run, no trigger lines touched; rate limited by the sensor
    wr(`EXP_ABS_OFS, 32'h5);
    wr(`CMD_OFS, 32'h1);
    wait_fs(3);
    chk("gap max rate", MINP, fs_gap);
    chk("exp abs", 32'd200, exposure_cycles_o);
    wr(`CTRL_OFS, 32'h20a);
    wait_fs(2);
    chk("exp raw", 32'd100, exposure_cycles_o);
    wr(`RATE_OFS, 32'd40);
    wr(`CTRL_OFS, 32'h4a);
    wait_fs(3);
    chk("gap rate", 32'd40, fs_gap);
    wr(`RATE_OFS, 32'd10);
    wait_fs(3);
    chk("gap clamp", MINP, fs_gap);
    wr(`CMD_OFS, 32'h2);
    idle(4);
    n = fs_count;
    idle(100);
    chk("after end", n, fs_count);
    // one-shot free run
    wr(`CTRL_OFS, 32'h08);
    wr(`CMD_OFS, 32'h1);
    idle(150);
    chk("one shot", n + 1, fs_count);
    // host triggers; the second lands while the sensor is busy
    busy_len <= 8'd40;
    wr(`CTRL_OFS, 32'h03);
    wr(`CMD_OFS, 32'h1);
    idle(1);
    chk("waiting host", 32'h1, {31'h0, waiting_o});
    n = fs_count;
    wr(`CMD_OFS, 32'h4);
    idle(2);
    chk("host frame", n + 1, fs_count);
    chk("host exp", 32'd200, exposure_cycles_o);
    chk("host width", 32'h0, {31'h0, exposure_by_width_o});
    wr(`CMD_OFS, 32'h4);
    idle(2);
    chk("dropped", n + 1, fs_count);
    rdc("ignored", `IGNORED_OFS, 32'h1, 32'h0000ffff);
    idle(50);
    wr(`CMD_OFS, 32'h4);
    idle(2);
    chk("host again", n + 2, fs_count);
    wr(`CMD_OFS, 32'h2);
    busy_len <= 8'h03;
    // both lines toggle, only the selected one and edge may count
    for (int i = 0; i < 4; i++) begin
      wr(`CTRL_OFS, LINE_CTL[i]);
      wr(`CMD_OFS, 32'h1);
      n = fs_count;
      i_model.lines(2'h3);
      idle(8);
      chk("after rise", n + 1 - i % 2, fs_count);
      i_model.lines(2'h0);
      idle(8);
      chk("after fall", n + 1, fs_count);
      chk("by width", 32'h1, {31'h0, exposure_by_width_o});
      wr(`CMD_OFS, 32'h2);
      idle(4);
    end
    // acquisition start gating and burst length
    wr(`BURST_OFS, 32'h2);
    wr(`CTRL_OFS, 32'h48b);
    wr(`CMD_OFS, 32'h1);
    idle(1);
    chk("wait acq", 32'h0, {31'h0, waiting_o});
    wr(`CMD_OFS, 32'h4);
    idle(1);
    chk("acq taken", 32'h1, {31'h0, waiting_o});
    n = fs_count;
    repeat (3) begin
      i_model.lines(2'h1);
      idle(8);
      i_model.lines(2'h0);
      idle(8);
    end
    chk("burst", n + 2, fs_count);
    rdc("burst state", `STATUS_OFS, 32'h2, 32'h0000001f);
    wr(`CMD_OFS, 32'h2);
    // invalid run mode: begin has no effect
    wr(`CTRL_OFS, 32'h04);
    n = fs_count;
    wr(`CMD_OFS, 32'h1);
    idle(60);
    chk("bad run mode", n, fs_count);
    chk("no wait", 32'h0, {31'h0, waiting_o});
    close_out();
  end
endmodule : frame_start_trigger_ctrl_tb
